// >>> src/apwp_port.sv
`timescale 1ns/1ps
// Summary of operation
// - Low lines three-state, gated by strobes
// - Word mode adds lines nine to eleven
// - Ten-bit word and low byte reads zero two low lines
// - Word select high: shared pin is bit8
// - Word select low: shared pin selects byte
// - Low byte travels on lines 0-7
// - High byte top four on lines 0-3
// - High byte read carries channel id
// - Ten-bit low byte read zeros two bits
// - Read when chip select and read low
module apwp_port #(
  parameter bit SHORT_RES = 1'b0
) (
  // Clock and reset
  input  wire logic        ref_clk,
  input  wire logic        nrst,
  input  wire logic        clk_en,
  // Host strobes
  input  wire logic        cs_n,
  input  wire logic        rd_n,
  input  wire logic        wr_n,
  input  wire logic        word_sel,
  // Low data lines
  input  wire logic [7:0]  low_data_lines_i,
  output logic      [7:0]  low_data_lines_o,
  output logic             low_data_lines_oe,
  // Shared bit 8 pin
  input  wire logic        bit8_or_upper_byte_enable_i,
  output logic             bit8_or_upper_byte_enable_o,
  output logic             bit8_or_upper_byte_enable_oe,
  // Upper word lines
  input  wire logic [2:0]  upper_word_data_lines_i,
  output logic      [2:0]  upper_word_data_lines_o,
  output logic             upper_word_data_lines_oe,
  // Conversion side
  input  wire logic [11:0] conv_result,
  input  wire logic [2:0]  conv_chan,
  output logic      [11:0] reg_wdata,
  output logic             reg_wr,
  output logic             reg_wr_upper,
  output logic             reg_wr_word
);
  apwp_lane_if lanes ();
  logic        rd_act;
  logic        wr_act;
  logic        upper_sel;
  logic [11:0] pin_word;
  logic [11:0] dout_r;
  logic [11:0] dout_nxt;
  logic        oe_low_r;
  logic        oe_low_nxt;
  logic        oe_b8_r;
  logic        oe_b8_nxt;
  logic        oe_hi_r;
  logic        oe_hi_nxt;
  logic        wr_prev_r;
  logic        wr_prev_nxt;
  logic        wr_r;
  logic        wr_nxt;
  logic [11:0] wdata_r;
  logic [11:0] wdata_nxt;
  logic        wup_r;
  logic        wup_nxt;
  logic        wword_r;
  logic        wword_nxt;

  // ----------------------------------------
  // Strobe decode
  // ----------------------------------------
  assign rd_act    = !cs_n && !rd_n;
  assign wr_act    = !cs_n && !wr_n;

  // ----------------------------------------
  // Byte select decode
  // ----------------------------------------
  assign upper_sel = !word_sel && bit8_or_upper_byte_enable_i;

  // ----------------------------------------
  // Lane interface to read mux
  // ----------------------------------------
  assign lanes.word_mode = word_sel;
  assign lanes.upper_sel = upper_sel;
  assign lanes.short_res = SHORT_RES;
  assign lanes.result    = conv_result;
  assign lanes.chan_id   = conv_chan;

  apwp_read_mux i_apwp_read_mux (
    .lanes (lanes)
  );

  // ----------------------------------------
  // Pin word assembly
  // ----------------------------------------
  for (genvar b = 0; b < apwp_pkg::DATA_W; b++) begin : g_pin
    if (b < apwp_pkg::LOW_LANES) begin : g_low
      assign pin_word[b] = low_data_lines_i[b];
    end else if (b == apwp_pkg::BIT8_POS) begin : g_b8
      assign pin_word[b] = bit8_or_upper_byte_enable_i;
    end else begin : g_up
      assign pin_word[b] = upper_word_data_lines_i[b-apwp_pkg::WORD_HI_LSB];
    end
  end

  // ----------------------------------------
  // Read path next state
  // ----------------------------------------
  always_comb begin
    dout_nxt   = dout_r;
    oe_low_nxt = 1'b0;
    oe_b8_nxt  = 1'b0;
    oe_hi_nxt  = 1'b0;
    if (rd_act) begin
      dout_nxt   = lanes.rd_word;
      oe_low_nxt = 1'b1;
      if (word_sel) begin
        oe_b8_nxt = 1'b1;
        oe_hi_nxt = 1'b1;
      end
    end
  end

  // ----------------------------------------
  // Read path registers
  // ----------------------------------------
  always_ff @(posedge ref_clk) begin
    if (!nrst) begin
      dout_r   <= apwp_pkg::REG_RST;
      oe_low_r <= 1'b0;
      oe_b8_r  <= 1'b0;
      oe_hi_r  <= 1'b0;
    end else if (clk_en) begin
      dout_r   <= dout_nxt;
      oe_low_r <= oe_low_nxt;
      oe_b8_r  <= oe_b8_nxt;
      oe_hi_r  <= oe_hi_nxt;
    end
  end

  // ----------------------------------------
  // Write strobe tracking
  // ----------------------------------------
  always_comb begin
    wr_prev_nxt = wr_act;
    wr_nxt      = 1'b0;
    if (wr_prev_r && !wr_act) begin
      wr_nxt = 1'b1;
    end
  end

  // ----------------------------------------
  // Write strobe registers
  // ----------------------------------------
  always_ff @(posedge ref_clk) begin
    if (!nrst) begin
      wr_prev_r <= 1'b0;
      wr_r      <= 1'b0;
    end else if (clk_en) begin
      wr_prev_r <= wr_prev_nxt;
      wr_r      <= wr_nxt;
    end
  end

  // ----------------------------------------
  // Write data capture
  // ----------------------------------------
  always_comb begin
    wdata_nxt = wdata_r;
    wup_nxt   = wup_r;
    wword_nxt = wword_r;
    if (wr_act) begin
      wword_nxt = word_sel;
      wup_nxt   = upper_sel;
      case ({word_sel, upper_sel})
        2'b10: begin
          wdata_nxt = pin_word;
        end
        2'b01: begin
          wdata_nxt = {4'h0, pin_word[7:0]};
        end
        default: begin
          wdata_nxt = {4'h0, pin_word[7:0]};
        end
      endcase
    end
  end

  // ----------------------------------------
  // Write data registers
  // ----------------------------------------
  always_ff @(posedge ref_clk) begin
    if (!nrst) begin
      wdata_r <= apwp_pkg::REG_RST;
      wup_r   <= 1'b0;
      wword_r <= 1'b0;
    end else if (clk_en) begin
      wdata_r <= wdata_nxt;
      wup_r   <= wup_nxt;
      wword_r <= wword_nxt;
    end
  end

  // ----------------------------------------
  // Host pin outputs
  // ----------------------------------------
  assign low_data_lines_o             = dout_r[7:0];
  assign low_data_lines_oe            = oe_low_r;
  assign bit8_or_upper_byte_enable_o  = dout_r[apwp_pkg::BIT8_POS];
  assign bit8_or_upper_byte_enable_oe = oe_b8_r;
  assign upper_word_data_lines_o      = dout_r[11:9];
  assign upper_word_data_lines_oe     = oe_hi_r;

  // ----------------------------------------
  // Register side outputs
  // ----------------------------------------
  assign reg_wdata                    = wdata_r;
  assign reg_wr                       = wr_r;
  assign reg_wr_upper                 = wup_r;
  assign reg_wr_word                  = wword_r;
endmodule

// >>> src/apwp_pkg.sv
package apwp_pkg;
  // ----------------------------------------
  // Widths and lane layout
  // ----------------------------------------
  localparam int DATA_W      = 12;
  localparam int LOW_LANES   = 8;
  localparam int HI_BITS     = 4;
  localparam int CH_W        = 3;
  localparam int CH_LSB      = 4;
  localparam int SHORT_PAD   = 2;
  localparam int WORD_HI_LSB = 9;
  localparam int WORD_HI_W   = 3;
  localparam int BIT8_POS    = 8;
  // ----------------------------------------
  // Reset values
  // ----------------------------------------
  localparam logic [11:0] REG_RST = 12'h000;
  localparam logic [2:0]  CH_RST  = 3'h0;
endpackage

// >>> src/apwp_lane_if.sv
`timescale 1ns/1ps
interface apwp_lane_if;
  logic        word_mode;
  logic        upper_sel;
  logic        short_res;
  logic [11:0] result;
  logic [2:0]  chan_id;
  logic [11:0] rd_word;
  modport mux  (input word_mode, input upper_sel, input short_res, input result,
                input chan_id, output rd_word);
  modport core (output word_mode, output upper_sel, output short_res, output result,
                output chan_id, input rd_word);
endinterface

// >>> src/apwp_read_mux.sv
`timescale 1ns/1ps
module apwp_read_mux (
  apwp_lane_if.mux lanes
);
  // ----------------------------------------
  // Read lane arrangement
  // ----------------------------------------
  logic [11:0] res_m;
  always_comb begin
    res_m = lanes.result;
    if (lanes.short_res) begin
      res_m[apwp_pkg::SHORT_PAD-1:0] = '0;
    end
    lanes.rd_word = '0;
    if (lanes.word_mode) begin
      lanes.rd_word = res_m;
    end else if (lanes.upper_sel) begin
      lanes.rd_word[apwp_pkg::HI_BITS-1:0] = res_m[11:8];
      lanes.rd_word[apwp_pkg::CH_LSB+:apwp_pkg::CH_W] = lanes.chan_id;
    end else begin
      lanes.rd_word[apwp_pkg::LOW_LANES-1:0] = res_m[7:0];
    end
  end
endmodule

// >>> test/apwp_port_props.sv
`timescale 1ns/1ps
// ----------
// Port checks
// ----------
module apwp_port_props #(
  parameter bit SHORT_RES = 1'b0
) (
  // Host side
  input wire logic        ref_clk,
  input wire logic        nrst,
  input wire logic        clk_en,
  input wire logic        cs_n,
  input wire logic        rd_n,
  input wire logic        wr_n,
  input wire logic        word_sel,
  input wire logic        bit8_or_upper_byte_enable_i,
  input wire logic        bit8_or_upper_byte_enable_oe,
  input wire logic [7:0]  low_data_lines_o,
  input wire logic        low_data_lines_oe,
  input wire logic [2:0]  upper_word_data_lines_o,
  input wire logic        upper_word_data_lines_oe,
  // Converter side
  input wire logic [11:0] conv_result,
  input wire logic [2:0]  conv_chan,
  input wire logic        reg_wr,
  input wire logic        reg_wr_word
);
  wire rd_q = clk_en && !cs_n && !rd_n;
  wire hb   = bit8_or_upper_byte_enable_i;
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!nrst);
  sequence wr_end;
    clk_en && !cs_n && !wr_n ##1 clk_en && (cs_n || wr_n);
  endsequence
  AST_RD_OE: assert property (rd_q |=> low_data_lines_oe)
    else $error("read not driven");
  AST_IDLE: assert property (clk_en && !rd_q |=> !low_data_lines_oe)
    else $error("bus not released");
  AST_WORD: assert property (rd_q && word_sel |=> bit8_or_upper_byte_enable_oe &&
    upper_word_data_lines_o == $past(conv_result[11:9])) else $error("word lanes");
  AST_BLO: assert property (rd_q && !word_sel && !hb |=> low_data_lines_o ==
    ($past(conv_result[7:0]) & (SHORT_RES ? 8'hfc : 8'hff))) else $error("low byte");
  AST_BHI: assert property (rd_q && !word_sel && hb |=> low_data_lines_o ==
    {1'b0, $past(conv_chan), $past(conv_result[11:8])}) else $error("high byte");
  AST_BNOUP: assert property (rd_q && !word_sel |=> !bit8_or_upper_byte_enable_oe &&
    !upper_word_data_lines_oe) else $error("shared pin driven");
  AST_WR: assert property (wr_end |=> reg_wr ##1 !reg_wr)
    else $error("write pulse");
  AST_WRW: assert property (wr_end |=> reg_wr_word == $past(word_sel, 2))
    else $error("write mode");
endmodule

// >>> test/apwp_host.sv
`timescale 1ns/1ps
// ----------
// Host master
// ----------
module apwp_host (
  input  wire logic        ref_clk,
  input  wire logic [11:0] pins,
  output logic             cs_n = 1'b1,
  output logic             rd_n = 1'b1,
  output logic             wr_n = 1'b1,
  output logic             word_sel = 1'b1,
  output logic             upper_byte_enable = 1'b0,
  output logic [11:0]      hd = 12'h000,
  output logic             hoe = 1'b0
);
  task automatic acc(input logic rd, input logic ws, input logic hb,
                     input logic [11:0] d, output logic [11:0] q);
    word_sel = ws;
    upper_byte_enable = hb;
    hd = d;
    hoe = !rd;
    cs_n = 1'b0;
    rd_n = !rd;
    wr_n = rd;
    repeat (2) @(posedge ref_clk);
    #5;
    q = pins;
    cs_n = 1'b1;
    rd_n = 1'b1;
    wr_n = 1'b1;
    hoe = 1'b0;
    @(posedge ref_clk);
    #5;
  endtask
endmodule

// >>> test/apwp_port_test.sv
`timescale 1ns/1ps
module apwp_port_test;
  logic        ref_clk = 1'b0;
  logic        nrst = 1'b0;
  logic        clk_en = 1'b1;
  logic        cs_n, rd_n, wr_n, word_sel, upper_byte_enable, hoe, reg_wr;
  logic        low_data_lines_oe, upper_word_data_lines_oe, reg_wr_upper, reg_wr_word;
  logic        bit8_or_upper_byte_enable_i, bit8_or_upper_byte_enable_o;
  logic        bit8_or_upper_byte_enable_oe;
  logic [11:0] conv_result = 12'ha5c;
  logic [2:0]  conv_chan = 3'h5;
  logic [11:0] hd, pins, q, reg_wdata;
  logic [7:0]  low_data_lines_i, low_data_lines_o;
  logic [2:0]  upper_word_data_lines_i, upper_word_data_lines_o;
  logic [7:0]  s_low;
  logic [2:0]  s_up;
  logic        s_b8;
  int          n_errors = 0;
  int          total_checks = 0;
  always #50 ref_clk = ~ref_clk;
  assign pins[7:0] = low_data_lines_oe ? low_data_lines_o : hoe ? hd[7:0] : ~low_data_lines_o;
  assign pins[8] = bit8_or_upper_byte_enable_oe ? bit8_or_upper_byte_enable_o :
                   !word_sel ? upper_byte_enable : hoe ? hd[8] : ~bit8_or_upper_byte_enable_o;
  assign pins[11:9] = upper_word_data_lines_oe ? upper_word_data_lines_o :
                      hoe ? hd[11:9] : ~upper_word_data_lines_o;
  assign low_data_lines_i = pins[7:0];
  assign bit8_or_upper_byte_enable_i = pins[8];
  assign upper_word_data_lines_i = pins[11:9];
  apwp_port i_apwp_port (.*);
  apwp_port #(.SHORT_RES(1'b1)) i_apwp_port_short (
    .ref_clk                      (ref_clk),
    .nrst                         (nrst),
    .clk_en                       (clk_en),
    .cs_n                         (cs_n),
    .rd_n                         (rd_n),
    .wr_n                         (wr_n),
    .word_sel                     (word_sel),
    .low_data_lines_i             (low_data_lines_i),
    .low_data_lines_o             (s_low),
    .low_data_lines_oe            (),
    .bit8_or_upper_byte_enable_i  (bit8_or_upper_byte_enable_i),
    .bit8_or_upper_byte_enable_o  (s_b8),
    .bit8_or_upper_byte_enable_oe (),
    .upper_word_data_lines_i      (upper_word_data_lines_i),
    .upper_word_data_lines_o      (s_up),
    .upper_word_data_lines_oe     (),
    .conv_result                  (conv_result),
    .conv_chan                    (conv_chan),
    .reg_wdata                    (),
    .reg_wr                       (),
    .reg_wr_upper                 (),
    .reg_wr_word                  ()
  );
  apwp_host i_apwp_host (.*);
  task automatic chk(input logic [11:0] got, input logic [11:0] exp);
    total_checks++;
    if (got !== exp) begin
      n_errors++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic final_report();
    $display("checks=%0d errors=%0d", total_checks, n_errors);
    if (n_errors == 0 && total_checks > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  initial begin
    #20000;
    n_errors++;
    final_report();
  end
  initial begin
    repeat (8) @(posedge ref_clk);
    #5;
    nrst = 1'b1;
    @(posedge ref_clk);
    #5;
    chk({11'h000, low_data_lines_oe}, 12'h000);
    i_apwp_host.acc(1'b1, 1'b1, 1'b0, 12'h000, q);
    chk(q, conv_result);
    chk({s_up, s_b8, s_low}, conv_result & 12'hffc);
    i_apwp_host.acc(1'b1, 1'b0, 1'b0, 12'h000, q);
    chk({4'h0, q[7:0]}, {4'h0, conv_result[7:0]});
    chk({4'h0, s_low}, {4'h0, conv_result[7:0] & 8'hfc});
    i_apwp_host.acc(1'b1, 1'b0, 1'b1, 12'h000, q);
    chk({4'h0, q[7:0]}, {5'h00, conv_chan, conv_result[11:8]});
    $display("reads done");
    i_apwp_host.acc(1'b0, 1'b1, 1'b0, 12'h3c5, q);
    chk(reg_wdata, 12'h3c5);
    chk({9'h000, reg_wr, reg_wr_word, reg_wr_upper}, 12'h006);
    i_apwp_host.acc(1'b0, 1'b0, 1'b0, 12'h096, q);
    chk(reg_wdata, 12'h096);
    chk({9'h000, reg_wr, reg_wr_word, reg_wr_upper}, 12'h004);
    i_apwp_host.acc(1'b0, 1'b0, 1'b1, 12'h00b, q);
    chk(reg_wdata, 12'h00b);
    chk({9'h000, reg_wr, reg_wr_word, reg_wr_upper}, 12'h005);
    chk({11'h000, low_data_lines_oe}, 12'h000);
    @(posedge ref_clk);
    #5;
    clk_en = 1'b0;
    i_apwp_host.acc(1'b0, 1'b1, 1'b0, 12'hfff, q);
    chk(reg_wdata, 12'h00b);
    clk_en = 1'b1;
    @(posedge ref_clk);
    #5;
    chk({9'h000, reg_wr, reg_wr_word, reg_wr_upper}, 12'h001);
    $display("writes done");
    final_report();
  end
endmodule
bind apwp_port apwp_port_props #(.SHORT_RES(SHORT_RES)) i_apwp_port_props (.*);
